//--- core/bearer_release_audit_fault_fsm.sv
// Purpose: exchange-side bearer release, audit and fault acknowledge control
// Assumes: rx messages pre-checked; tx link takes a word on txValid && txReady
// Notes: fault acks take the transmit stage ahead of own messages
module bearer_release_audit_fault_fsm #(
  parameter int unsigned REL_CYCLES = bcc_pkg::REL_TIMER_CYCLES,
  parameter int unsigned AUD_CYCLES = bcc_pkg::AUD_TIMER_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Release request from resource manager
  input wire logic relReq,
  input wire logic [bcc_pkg::TS_W-1:0] relTs,
  input wire logic [bcc_pkg::PORT_W-1:0] relPort,
  output logic relReady,
  // Audit request from resource manager
  input wire logic audReq,
  input wire logic [bcc_pkg::TS_W-1:0] audTs,
  input wire logic [bcc_pkg::PORT_W-1:0] audPort,
  output logic audReady,
  // Release indications
  output logic relConfirm,
  output logic relReject,
  output logic [bcc_pkg::CAUSE_W-1:0] relCause,
  output logic relError,
  // Audit indications
  output logic audConfirm,
  output logic [bcc_pkg::TS_W-1:0] audResultTs,
  output logic [bcc_pkg::PORT_W-1:0] audResultPort,
  output logic audError,
  // Fault indication
  output logic faultInd,
  output logic [bcc_pkg::TS_W-1:0] faultTs,
  output logic [bcc_pkg::PORT_W-1:0] faultPort,
  // Received messages
  input wire logic rxValid,
  input wire bcc_pkg::msg_kind_t rxKind,
  input wire logic [bcc_pkg::REF_W-1:0] rxRef,
  input wire logic [bcc_pkg::TS_W-1:0] rxTs,
  input wire logic [bcc_pkg::PORT_W-1:0] rxPort,
  input wire logic [bcc_pkg::CAUSE_W-1:0] rxCause,
  // Transmitted messages
  output logic txValid,
  output bcc_pkg::msg_kind_t txKind,
  output logic [bcc_pkg::REF_W-1:0] txRef,
  output logic [bcc_pkg::TS_W-1:0] txTs,
  output logic [bcc_pkg::PORT_W-1:0] txPort,
  input wire logic txReady
);
  import bcc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEND_REL,
    ST_WAIT_REL,
    ST_SEND_AUD,
    ST_WAIT_AUD
  } state_t;

  state_t state;
  state_t next_state;
  logic [REF_W-1:0] curRef;
  logic [REF_W-1:0] refCounter;
  logic [TS_W-1:0] curTs;
  logic [PORT_W-1:0] curPort;
  logic resend;
  logic isIdle;
  logic inRel;
  logic inAud;
  logic refMatch;
  logic relDone;
  logic relRej;
  logic audDone;
  logic idleDone;
  logic idleRej;
  logic relClose;
  logic txFree;
  logic ownSend;
  logic ownTaken;
  logic startRel;
  logic startAud;

  timer_ctl_if relTmr();
  timer_ctl_if audTmr();
  ack_msg_if ackMsg();

  supervision_timer #(
    .CYCLES(REL_CYCLES)
  ) u_rel_timer (
    .core_clk(core_clk),
    .rst(rst),
    .ctl(relTmr.timer)
  );

  supervision_timer #(
    .CYCLES(AUD_CYCLES)
  ) u_aud_timer (
    .core_clk(core_clk),
    .rst(rst),
    .ctl(audTmr.timer)
  );

  fault_ack_responder u_fault (
    .core_clk(core_clk),
    .rst(rst),
    .rxValid(rxValid),
    .rxKind(rxKind),
    .rxRef(rxRef),
    .rxTs(rxTs),
    .rxPort(rxPort),
    .faultInd(faultInd),
    .faultTs(faultTs),
    .faultPort(faultPort),
    .ack(ackMsg.src)
  );

  // Replies are matched by reference; stale or foreign ones fall through
  assign isIdle = state == ST_IDLE;
  assign inRel = state == ST_SEND_REL || state == ST_WAIT_REL;
  assign inAud = state == ST_SEND_AUD || state == ST_WAIT_AUD;
  assign refMatch = rxValid && rxRef == curRef;
  assign relDone = inRel && refMatch && rxKind == MSG_DEALLOC_DONE;
  assign relRej = inRel && refMatch && rxKind == MSG_DEALLOC_REJ;
  assign audDone = inAud && refMatch && rxKind == MSG_AUDIT_DONE;
  assign idleDone = isIdle && rxValid && rxKind == MSG_DEALLOC_DONE;
  assign idleRej = isIdle && rxValid && rxKind == MSG_DEALLOC_REJ;
  assign relClose = relDone || relRej;

  assign relReady = isIdle;
  assign audReady = isIdle && !relReq;
  assign startRel = isIdle && relReq;
  assign startAud = isIdle && audReq && !relReq;

  // Transmit stage: ack first, so a far-side fault timer is not starved
  assign txFree = !txValid || txReady;
  assign ackMsg.ready = txFree;
  assign ownSend = (state == ST_SEND_REL && !relClose) || (state == ST_SEND_AUD && !audDone);
  assign ownTaken = ownSend && txFree && !ackMsg.valid;

  // Timer runs from the moment the message is committed to the link
  assign relTmr.start = ownTaken && state == ST_SEND_REL;
  assign relTmr.fresh = !resend;
  assign relTmr.stop = relClose;
  assign audTmr.start = ownTaken && state == ST_SEND_AUD;
  assign audTmr.fresh = !resend;
  assign audTmr.stop = audDone;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (relReq) begin
          next_state = ST_SEND_REL;
        end else if (audReq) begin
          next_state = ST_SEND_AUD;
        end
      end
      ST_SEND_REL: begin
        if (relClose) begin
          next_state = ST_IDLE;
        end else if (ownTaken) begin
          next_state = ST_WAIT_REL;
        end
      end
      ST_WAIT_REL: begin
        if (relClose) begin
          next_state = ST_IDLE;
        end else if (relTmr.retry) begin
          next_state = ST_SEND_REL;
        end else if (relTmr.giveUp) begin
          next_state = ST_IDLE;
        end
      end
      ST_SEND_AUD: begin
        if (audDone) begin
          next_state = ST_IDLE;
        end else if (ownTaken) begin
          next_state = ST_WAIT_AUD;
        end
      end
      ST_WAIT_AUD: begin
        if (audDone) begin
          next_state = ST_IDLE;
        end else if (audTmr.retry) begin
          next_state = ST_SEND_AUD;
        end else if (audTmr.giveUp) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Procedure context; a resend reuses slot and reference unchanged
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      curRef <= REF_RESET;
      refCounter <= REF_RESET;
      curTs <= '0;
      curPort <= '0;
      resend <= 1'b0;
    end else if (startRel || startAud) begin
      curRef <= refCounter;
      refCounter <= refCounter + 1'b1;
      curTs <= startRel ? relTs : audTs;
      curPort <= startRel ? relPort : audPort;
      resend <= 1'b0;
    end else if (relTmr.retry || audTmr.retry) begin
      resend <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txValid <= 1'b0;
      txKind <= MSG_NONE;
      txRef <= REF_RESET;
      txTs <= '0;
      txPort <= '0;
    end else if (txFree) begin
      if (ackMsg.valid) begin
        txValid <= 1'b1;
        txKind <= MSG_FAULT_ACK;
        txRef <= ackMsg.refNum;
        txTs <= '0;
        txPort <= '0;
      end else if (ownSend) begin
        txValid <= 1'b1;
        txKind <= state == ST_SEND_REL ? MSG_DEALLOC : MSG_AUDIT;
        txRef <= curRef;
        txTs <= curTs;
        txPort <= curPort;
      end else begin
        txValid <= 1'b0;
      end
    end
  end

  // Indications are one-cycle pulses with registered data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      relConfirm <= 1'b0;
      relReject <= 1'b0;
      relCause <= '0;
      relError <= 1'b0;
    end else begin
      relConfirm <= relDone || idleDone;
      relReject <= relRej || idleRej;
      relError <= state == ST_WAIT_REL && relTmr.giveUp && !relClose;
      if (relRej || idleRej) begin
        relCause <= rxCause;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      audConfirm <= 1'b0;
      audResultTs <= '0;
      audResultPort <= '0;
      audError <= 1'b0;
    end else begin
      audConfirm <= audDone;
      audError <= state == ST_WAIT_AUD && audTmr.giveUp && !audDone;
      if (audDone) begin
        audResultTs <= rxTs;
        audResultPort <= rxPort;
      end
    end
  end

  a_rel_request: assert property (@(posedge core_clk) disable iff (rst)
    isIdle && relReq |=> state == ST_SEND_REL && curTs == $past(relTs))
    else $error("release request not taken up");

  a_rel_message: assert property (@(posedge core_clk) disable iff (rst)
    ownTaken && state == ST_SEND_REL |=> txValid && txKind == MSG_DEALLOC && txRef == curRef)
    else $error("release message not loaded");

  a_rel_wait: assert property (@(posedge core_clk) disable iff (rst)
    ownTaken && state == ST_SEND_REL |-> relTmr.start ##1 state == ST_WAIT_REL)
    else $error("release timer or wait state missing");

  a_rel_confirm: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_WAIT_REL && refMatch && rxKind == MSG_DEALLOC_DONE
    |-> relTmr.stop ##1 relConfirm && isIdle)
    else $error("matching release complete not confirmed");

  a_rel_resend: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_WAIT_REL && relTmr.retry && !relClose |=> state == ST_SEND_REL && resend)
    else $error("first release expiry did not resend");

  a_rel_giveup: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_WAIT_REL && relTmr.giveUp && !relClose |=> relError && isIdle)
    else $error("second release expiry not reported");

  a_idle_confirm: assert property (@(posedge core_clk) disable iff (rst)
    idleDone && !relReq && !audReq |=> relConfirm && isIdle)
    else $error("stray complete not confirmed");

  a_rel_reject: assert property (@(posedge core_clk) disable iff (rst)
    relRej |-> relTmr.stop ##1 relReject && isIdle && relCause == $past(rxCause))
    else $error("matching reject not handled");

  a_idle_reject: assert property (@(posedge core_clk) disable iff (rst)
    idleRej |=> relReject && !relConfirm)
    else $error("stray reject not indicated");

  a_aud_message: assert property (@(posedge core_clk) disable iff (rst)
    ownTaken && state == ST_SEND_AUD |=> txValid && txKind == MSG_AUDIT && txTs == curTs)
    else $error("audit message not loaded");

  a_aud_wait: assert property (@(posedge core_clk) disable iff (rst)
    ownTaken && state == ST_SEND_AUD |-> audTmr.start ##1 state == ST_WAIT_AUD)
    else $error("audit timer or wait state missing");

  a_aud_confirm: assert property (@(posedge core_clk) disable iff (rst)
    audDone |=> audConfirm && isIdle && audResultTs == $past(rxTs))
    else $error("matching audit complete not confirmed");

  a_aud_resend: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_WAIT_AUD && audTmr.retry && !audDone |=> state == ST_SEND_AUD)
    else $error("first audit expiry did not resend");

  a_aud_giveup: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_WAIT_AUD && audTmr.giveUp && !audDone |=> audError && isIdle)
    else $error("second audit expiry not reported");
endmodule : bearer_release_audit_fault_fsm

//--- include/bcc_pkg.sv
// Purpose: shared constants and message kinds for the exchange-side bearer control block
// Assumes: 100 MHz core clock; message framing and error checks done upstream
// Notes: timer figures are plain defaults, overridable at the top level
// Functional notes
// - Idle release request sends DE-ALLOCATION naming the slots to free.
// - Sending DE-ALLOCATION starts release timer and enters release wait.
// - Matching complete reports confirmation, stops release timer, returns idle.
// - First release timeout resends DE-ALLOCATION, restarts timer, keeps waiting.
// - Second release timeout abandons release, returns idle, flags release error.
// - Complete while idle still gives release confirmation and stays idle.
// - Matching reject stops release timer, reports reject, returns idle.
// - Reject while idle gives reject indication and stays idle.
// - Idle audit request sends AUDIT naming one 64 kbit/s slot or port.
// - Sending AUDIT starts audit timer and enters audit wait.
// - Matching audit complete stops audit timer, confirms, returns idle.
// - First audit timeout resends AUDIT, restarts timer, keeps waiting.
// - Second audit timeout ends audit, returns idle, flags audit error.
// - Received AN FAULT raises fault indication and is acknowledged.
package bcc_pkg;
  typedef enum logic [2:0] {
    MSG_NONE,
    MSG_DEALLOC,
    MSG_DEALLOC_DONE,
    MSG_DEALLOC_REJ,
    MSG_AUDIT,
    MSG_AUDIT_DONE,
    MSG_FAULT,
    MSG_FAULT_ACK
  } msg_kind_t;

  localparam int REF_W = 13;
  localparam int TS_W = 13;
  localparam int PORT_W = 16;
  localparam int CAUSE_W = 8;
  localparam int TIMER_W = 32;
  localparam logic [REF_W-1:0] REF_RESET = 13'h0000;

  localparam int CLK_MHZ = 100;
  localparam int REL_TIMEOUT_US = 2000;
  localparam int AUD_TIMEOUT_US = 2000;
  localparam int REL_TIMER_CYCLES = REL_TIMEOUT_US * CLK_MHZ;
  localparam int AUD_TIMER_CYCLES = AUD_TIMEOUT_US * CLK_MHZ;
endpackage : bcc_pkg

//--- include/timer_ctl_if.sv
// Purpose: control and events between a procedure and its supervision timer
// Assumes: all signals on core_clk
// Notes: start with fresh set clears the expiry history
interface timer_ctl_if;
  logic start;
  logic fresh;
  logic stop;
  logic retry;
  logic giveUp;
  modport owner(output start, fresh, stop, input retry, giveUp);
  modport timer(input start, fresh, stop, output retry, giveUp);
endinterface : timer_ctl_if

//--- include/ack_msg_if.sv
// Purpose: pending fault acknowledge offered to the transmit stage
// Assumes: valid/ready handshake on core_clk
// Notes: refNum echoes the reference of the fault report
interface ack_msg_if;
  logic valid;
  logic ready;
  logic [bcc_pkg::REF_W-1:0] refNum;
  modport src(output valid, refNum, input ready);
  modport sink(input valid, refNum, output ready);
endinterface : ack_msg_if

//--- core/supervision_timer.sv
// Purpose: supervision timer with a one-retry expiry history
// Assumes: owner restarts it after each retransmission
// Notes: stops itself on expiry; events are one-cycle pulses
module supervision_timer #(
  parameter int unsigned CYCLES = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  timer_ctl_if.timer ctl
);
  import bcc_pkg::*;

  logic running;
  logic expCount;
  logic [TIMER_W-1:0] count;
  logic lastTick;

  assign lastTick = running && !ctl.start && !ctl.stop && count == TIMER_W'(CYCLES - 1);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      count <= '0;
    end else if (ctl.start) begin
      running <= 1'b1;
      count <= '0;
    end else if (ctl.stop || lastTick) begin
      running <= 1'b0;
      count <= '0;
    end else if (running) begin
      count <= count + 1'b1;
    end
  end

  // One retransmission, then give up
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      expCount <= 1'b0;
    end else if (ctl.start && ctl.fresh) begin
      expCount <= 1'b0;
    end else if (lastTick) begin
      expCount <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl.retry <= 1'b0;
      ctl.giveUp <= 1'b0;
    end else begin
      ctl.retry <= lastTick && !expCount;
      ctl.giveUp <= lastTick && expCount;
    end
  end

  a_retry_once: assert property (@(posedge core_clk) disable iff (rst)
    ctl.retry |-> expCount && !running)
    else $error("retry without recorded first expiry");

  a_fresh_clears: assert property (@(posedge core_clk) disable iff (rst)
    ctl.start && ctl.fresh |=> !expCount && running && count == '0)
    else $error("fresh start did not clear timer history");
endmodule : supervision_timer

//--- core/fault_ack_responder.sv
// Purpose: answers far-side fault reports and raises the fault indication
// Assumes: messages arrive already checked, one per cycle at most
// Notes: a second report before the first ack leaves keeps only the newest
module fault_ack_responder (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Received message
  input wire logic rxValid,
  input wire bcc_pkg::msg_kind_t rxKind,
  input wire logic [bcc_pkg::REF_W-1:0] rxRef,
  input wire logic [bcc_pkg::TS_W-1:0] rxTs,
  input wire logic [bcc_pkg::PORT_W-1:0] rxPort,
  // Indication to resource manager
  output logic faultInd,
  output logic [bcc_pkg::TS_W-1:0] faultTs,
  output logic [bcc_pkg::PORT_W-1:0] faultPort,
  // Acknowledge toward transmit stage
  ack_msg_if.src ack
);
  import bcc_pkg::*;

  logic pending;
  logic newFault;

  assign newFault = rxValid && rxKind == MSG_FAULT;
  assign ack.valid = pending;

  // New report wins over the ack leaving in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pending <= 1'b0;
      ack.refNum <= REF_RESET;
    end else if (newFault) begin
      pending <= 1'b1;
      ack.refNum <= rxRef;
    end else if (ack.ready) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      faultInd <= 1'b0;
      faultTs <= '0;
      faultPort <= '0;
    end else begin
      faultInd <= newFault;
      if (newFault) begin
        faultTs <= rxTs;
        faultPort <= rxPort;
      end
    end
  end

  a_fault_answer: assert property (@(posedge core_clk) disable iff (rst)
    newFault |=> faultInd && ack.valid && ack.refNum == $past(rxRef))
    else $error("fault report not indicated or not queued for ack");
endmodule : fault_ack_responder

//--- tb/an_model.sv
// Purpose: access-network side stand-in that answers the exchange-side block
// Assumes: drives its outputs by non-blocking assignment on the rising edge
// Notes: mode 0 completes, 1 rejects releases but completes audits, 2 stays silent; accept stalls are random
module an_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Words from the block
  input wire logic txValid,
  input wire bcc_pkg::msg_kind_t txKind,
  input wire logic [bcc_pkg::REF_W-1:0] txRef,
  input wire logic [bcc_pkg::TS_W-1:0] txTs,
  input wire logic [bcc_pkg::PORT_W-1:0] txPort,
  output logic txReady,
  // Words to the block
  output logic rxValid,
  output bcc_pkg::msg_kind_t rxKind,
  output logic [bcc_pkg::REF_W-1:0] rxRef,
  output logic [bcc_pkg::TS_W-1:0] rxTs,
  output logic [bcc_pkg::PORT_W-1:0] rxPort,
  output logic [bcc_pkg::CAUSE_W-1:0] rxCause,
  // Bench control
  input wire logic [1:0] mode,
  input wire logic [bcc_pkg::CAUSE_W-1:0] cause,
  input wire logic injGo,
  input wire bcc_pkg::msg_kind_t injKind,
  input wire logic [bcc_pkg::REF_W-1:0] injRef,
  output int ackCnt,
  output logic [bcc_pkg::REF_W-1:0] ackRef
);
  timeunit 1ns;
  timeprecision 100ps;
  import bcc_pkg::*;
  logic [44:0] pend[$];
  logic [44:0] m;
  int gap;
  initial begin
    rxKind = MSG_NONE;
    rxRef = '0;
    rxTs = '0;
    rxPort = '0;
    rxCause = '0;
    ackCnt = 0;
    ackRef = '0;
    gap = 0;
  end
  always @(posedge clk) begin
    if (rst) begin
      txReady <= 1'b0;
      rxValid <= 1'b0;
    end else begin
      if (txValid && txReady) begin
        pend.push_back({txKind, txRef, txTs, txPort});
      end
      txReady <= ($urandom_range(3, 0) != 0);
      rxValid <= 1'b0;
      // Released lines keep moving so stale values never look valid
      rxRef <= ~rxRef;
      rxTs <= ~rxTs;
      rxPort <= ~rxPort;
      rxCause <= ~rxCause;
      rxKind <= msg_kind_t'(~rxKind);
      if (injGo) begin
        rxValid <= 1'b1;
        rxKind <= injKind;
        rxRef <= injRef;
        rxTs <= injRef;
        rxPort <= {injRef, 3'h5};
        rxCause <= cause;
      end else if (gap > 0) begin
        gap--;
      end else if (pend.size() > 0) begin
        m = pend.pop_front();
        gap = $urandom_range(6, 0);
        rxRef <= m[41:29];
        rxTs <= m[28:16];
        rxPort <= m[15:0];
        rxCause <= cause;
        case (m[44:42])
          3'(MSG_DEALLOC): begin
            rxValid <= (mode != 2'h2);
            rxKind <= (mode == 2'h1) ? MSG_DEALLOC_REJ : MSG_DEALLOC_DONE;
          end
          3'(MSG_AUDIT): begin
            rxValid <= (mode != 2'h2);
            rxKind <= MSG_AUDIT_DONE;
          end
          3'(MSG_FAULT_ACK): begin
            ackCnt <= ackCnt + 1;
            ackRef <= m[41:29];
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule : an_model

//--- tb/tb.sv
// Purpose: self-checking bench for the exchange-side release, audit and fault block
// Assumes: short supervision timers; far side modelled by an_model
// Notes: expected words and indications are predicted before each procedure starts
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import bcc_pkg::*;
  localparam int CYC = 20;
  logic coreClk = 1'b0;
  logic rst = 1'b1;
  logic relReq = 1'b0, audReq = 1'b0, relReady, audReady, txReady, rxValid, injGo = 1'b0;
  logic [TS_W-1:0] relTs = '0, audTs = '0, rxTs, audResultTs, faultTs, lastTs;
  logic [PORT_W-1:0] relPort = '0, audPort = '0, rxPort, audResultPort, faultPort, lastPort;
  logic relConfirm, relReject, relError, audConfirm, audError, faultInd, txValid;
  logic [CAUSE_W-1:0] relCause, rxCause, cause = '0;
  logic [REF_W-1:0] rxRef, txRef, ackRef;
  logic [TS_W-1:0] txTs;
  logic [PORT_W-1:0] txPort;
  logic [1:0] mode = 2'h0;
  msg_kind_t rxKind, txKind, injKind = MSG_NONE;
  logic [REF_W-1:0] injRef = '0;
  logic [44:0] expTx[$];
  logic [44:0] wantTx;
  int seen[6], expd[6];
  int miscompares = 0, checked = 0, curRef = 0, cyc = 0, tStart = 0, tEnd = 0, ackCnt;

  always #5 coreClk = ~coreClk;

  bearer_release_audit_fault_fsm #(.REL_CYCLES(CYC), .AUD_CYCLES(CYC))
    i_bearer_release_audit_fault_fsm (
    .core_clk(coreClk), .rst(rst), .relReq(relReq), .relTs(relTs), .relPort(relPort),
    .relReady(relReady), .audReq(audReq), .audTs(audTs), .audPort(audPort),
    .audReady(audReady), .relConfirm(relConfirm), .relReject(relReject),
    .relCause(relCause), .relError(relError), .audConfirm(audConfirm),
    .audResultTs(audResultTs), .audResultPort(audResultPort), .audError(audError),
    .faultInd(faultInd), .faultTs(faultTs), .faultPort(faultPort), .rxValid(rxValid),
    .rxKind(rxKind), .rxRef(rxRef), .rxTs(rxTs), .rxPort(rxPort), .rxCause(rxCause),
    .txValid(txValid), .txKind(txKind), .txRef(txRef), .txTs(txTs), .txPort(txPort),
    .txReady(txReady));

  an_model i_an_model (
    .clk(coreClk), .rst(rst), .txValid(txValid), .txKind(txKind), .txRef(txRef),
    .txTs(txTs), .txPort(txPort), .txReady(txReady), .rxValid(rxValid), .rxKind(rxKind),
    .rxRef(rxRef), .rxTs(rxTs), .rxPort(rxPort), .rxCause(rxCause), .mode(mode),
    .cause(cause), .injGo(injGo), .injKind(injKind), .injRef(injRef), .ackCnt(ackCnt),
    .ackRef(ackRef));

  task automatic check(input logic [63:0] got, input logic [63:0] want);
    checked++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, got, want);
    end
  endtask : check

  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // Pre-edge values are seen here, so each one-cycle pulse counts once
  always @(posedge coreClk) begin
    if (!rst) begin
      cyc++;
      seen[0] += int'(relConfirm === 1'b1);
      seen[1] += int'(relReject === 1'b1);
      seen[2] += int'(relError === 1'b1);
      seen[3] += int'(audConfirm === 1'b1);
      seen[4] += int'(audError === 1'b1);
      seen[5] += int'(faultInd === 1'b1);
      if (txValid === 1'b1 && txReady) begin
        wantTx = expTx.size() ? expTx.pop_front() : '1;
        check({txKind, txRef, txTs, txPort}, wantTx);
      end
    end
  end

  task automatic run_proc(input bit aud, input logic [1:0] m);
    logic [44:0] word;
    lastTs = TS_W'($urandom);
    lastPort = PORT_W'($urandom);
    word = {aud ? 3'(MSG_AUDIT) : 3'(MSG_DEALLOC), curRef[REF_W-1:0], lastTs, lastPort};
    @(negedge coreClk);
    mode = m;
    cause = CAUSE_W'($urandom);
    while (!(aud ? audReady : relReady)) @(negedge coreClk);
    if (aud) {audReq, audTs, audPort} = {1'b1, lastTs, lastPort};
    else {relReq, relTs, relPort} = {1'b1, lastTs, lastPort};
    expTx.push_back(word);
    if (m == 2'h2) expTx.push_back(word);
    expd[m == 2'h2 ? (aud ? 4 : 2) : (aud ? 3 : int'(m))]++;
    tStart = cyc;
    curRef++;
    @(negedge coreClk);
    relReq = 1'b0;
    audReq = 1'b0;
    check({relReady, audReady}, 2'h0);
  endtask : run_proc

  task automatic settle();
    int n;
    n = 0;
    while ((seen != expd || expTx.size() != 0) && n < 600) begin
      @(negedge coreClk);
      n++;
    end
    tEnd = cyc - tStart;
    repeat (3) @(negedge coreClk);
    for (int i = 0; i < 6; i++) check(seen[i], expd[i]);
    check(expTx.size(), 0);
    check(relReady, 1'b1);
    check(audReady, 1'b1);
  endtask : settle

  task automatic inject(input msg_kind_t k, input logic [REF_W-1:0] r);
    @(negedge coreClk);
    {injGo, injKind, injRef} = {1'b1, k, r};
    if (k == MSG_FAULT) expTx.push_front({MSG_FAULT_ACK, r, 13'h0, 16'h0});
    expd[k == MSG_FAULT ? 5 : (k == MSG_DEALLOC_REJ ? 1 : 0)]++;
    @(negedge coreClk);
    injGo = 1'b0;
  endtask : inject

  task automatic fault_check(input logic [REF_W-1:0] r, input int acks);
    check(faultTs, r);
    check(faultPort, {r, 3'h5});
    check(ackRef, r);
    check(ackCnt, acks);
  endtask : fault_check

  initial begin
    void'($urandom(32'h6468AA84));
    foreach (seen[i]) {seen[i], expd[i]} = '0;
    repeat (12) @(negedge coreClk);
    rst = 1'b0;
    for (int rep = 0; rep < 2; rep++) begin
      for (int m = 0; m < 3; m++) begin
        run_proc(1'b0, 2'(m));
        settle();
        if (m == 1) check(relCause, cause);
        if (m == 2) check(tEnd inside {[2 * CYC : 2 * CYC + 60]}, 1);
        run_proc(1'b1, 2'(m));
        settle();
        if (m == 0) check({audResultTs, audResultPort}, {lastTs, lastPort});
        if (m == 2) check(tEnd inside {[2 * CYC : 2 * CYC + 60]}, 1);
      end
    end
    // Stray replies while idle
    inject(MSG_DEALLOC_DONE, 13'h0ABC);
    cause = CAUSE_W'($urandom);
    inject(MSG_DEALLOC_REJ, 13'h1234);
    settle();
    check(relCause, cause);
    // Fault report while idle, far-side resend, then one during a silent release
    inject(MSG_FAULT, 13'h1F0F);
    settle();
    fault_check(13'h1F0F, 1);
    inject(MSG_FAULT, 13'h1F0F);
    settle();
    fault_check(13'h1F0F, 2);
    run_proc(1'b0, 2'h2);
    while (expTx.size() > 1) @(negedge coreClk);
    inject(MSG_FAULT, 13'h0777);
    settle();
    fault_check(13'h0777, 3);
    // Back-to-back procedures
    run_proc(1'b0, 2'h0);
    run_proc(1'b1, 2'h0);
    settle();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge coreClk);
    miscompares++;
    end_of_test();
  end
endmodule : tb
